//--- src/acp_drive.sv
// drive end: capacity limit, block count and low-power command handler
// assumes task-file values stable while cmdValid pulses; host waits for !busy
//
// What this block does
// - set-max takes address from head/cyl/sector registers
// - host sets lba bit and picks device
// - host sends set-max only after read-native, ready
// - count bit 0 selects persistent limit
// - features picks password, lock, unlock, freeze
// - abort second persistent set-max after reset
// - set-multiple: busy, then check count
// - supported count stored, multi-sector enabled
// - unsupported count aborts, multi-sector disabled
// - zero count disables multi-sector commands
// - multi-sector disabled after power-on
// - 99h and e6h mean sleep
// - 96h and e2h mean standby
// - 94h and e0h mean standby immediate
// - low-power: busy, enter, finish, interrupt at once
// - any new command wakes the drive
// - monitoring command needs signature bytes
// - identify word 82 bit 0 reports monitoring
// - multi write aborts when block mode off
// - only block count one supported
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "acp_defs.svh"
module acp_drive (
	input wire logic sys_clk,
	input wire logic rst_n,
	acp_link_if.drive link,
	output logic [27:0] nvMaxLba,
	output logic maxLocked,
	output logic maxFrozen,
	output logic smartReq,
	output logic [7:0] smartFeat
);
	import acp_pkg::*;

	acp_dstate_t state_q, state_d; // handler state
	acp_pwr_t pwr_q; // power state
	logic [7:0] op_q; // latched opcode
	logic [7:0] feat_q; // latched features
	logic [7:0] cnt_q; // latched sector count
	logic [27:0] lba_q; // latched address
	logic [27:0] curMax_q; // current volatile limit
	logic [27:0] nvMax_q; // last persistent limit
	logic nativeOk_q; // previous command was a good read-native
	logic nvSetDone_q; // persistent set-max seen since reset
	logic multEn_q; // block mode on
	logic multSet_q; // set-multiple has run
	logic abort_q; // error of last command
	logic done_q; // completion pulse
	logic locked_q; // set-max locked
	logic frozen_q; // set-max frozen
	logic pwSet_q; // password installed
	logic smartReq_q; // monitoring pulse out
	logic [7:0] smartFeat_q;
	logic busy_q; // busy pin, off a flop like every link output but the constant idWord82
	logic ready_q; // ready pin, inverse of busy_q
	logic isSleep, isStandby, isStandbyNow, isSmart;
	logic isSetMax, isNative, isSetMult, isMulti;

	acp_opdec acp_opdec_i (
		.opcode(op_q),
		.cylLow(lba_q[15:8]),
		.cylHigh(lba_q[23:16]),
		.isSleep(isSleep),
		.isStandby(isStandby),
		.isStandbyNow(isStandbyNow),
		.isSmart(isSmart),
		.isSetMax(isSetMax),
		.isNative(isNative),
		.isSetMult(isSetMult),
		.isMulti(isMulti)
	);

	// decisions made in the busy cycle
	wire lowPower = isSleep || isStandby || isStandbyNow;
	wire persist = cnt_q[`ACP_SC_PERSIST_BIT];
	wire featCode = (feat_q == 8'h00); // plain set-max (legacy subcode)
	// set-max checks: order, persistence repeat, lock, freeze
	wire setMaxBad = !nativeOk_q || (persist && nvSetDone_q) || (locked_q && featCode)
		|| (frozen_q && (feat_q != 8'h00)) || (feat_q > `ACP_FEAT_FREEZE);
	wire countOk = (cnt_q == `ACP_BLOCK_SUPPORTED);
	wire multBad = isSetMult && (cnt_q != 8'h00) && !countOk;
	wire multiBad = isMulti && (!multSet_q || !multEn_q);
	wire setMaxFail = isSetMax && setMaxBad;
	wire anyAbort = setMaxFail || multBad || multiBad;

	// next state: idle, busy one cycle, done pulse
	always_comb begin
		state_d = state_q;
		case (state_q)
			ACP_DS_IDLE: begin
				if (link.cmdValid) begin
					state_d = ACP_DS_BUSY;
				end
			end
			ACP_DS_BUSY: state_d = ACP_DS_DONE; // low power finishes at once
			ACP_DS_DONE: state_d = ACP_DS_IDLE;
			default: state_d = ACP_DS_IDLE;
		endcase
	end

	// state register; busy/ready follow the next state so they stand with BUSY
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ACP_DS_IDLE;
			busy_q <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			busy_q <= (state_d == ACP_DS_BUSY);
			ready_q <= (state_d != ACP_DS_BUSY);
		end
	end

	// capture the task file on issue
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= 8'h00;
			feat_q <= 8'h00;
			cnt_q <= 8'h00;
			lba_q <= 28'h0000000;
		end else if (link.cmdValid && state_q == ACP_DS_IDLE) begin
			op_q <= link.cmdOpcode;
			feat_q <= link.featReg;
			cnt_q <= link.countReg;
			lba_q <= {link.driveHead[3:0], link.cylHigh, link.cylLow, link.sectNum};
		end
	end

	// power state; any command wakes first
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= ACP_PWR_ACTIVE;
		end else if (link.cmdValid && state_q == ACP_DS_IDLE) begin
			pwr_q <= ACP_PWR_ACTIVE;
		end else if (state_q == ACP_DS_BUSY && lowPower) begin
			pwr_q <= isSleep ? ACP_PWR_SLEEP : ACP_PWR_STANDBY;
		end
	end

	// capacity limit; reset loads ACP_NATIVE_MAX_RST into both the current and the persistent value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			curMax_q <= `ACP_NATIVE_MAX_RST;
			nvMax_q <= `ACP_NATIVE_MAX_RST;
			nvSetDone_q <= 1'b0;
			locked_q <= 1'b0;
			frozen_q <= 1'b0;
			pwSet_q <= 1'b0;
		end else begin
			if (state_q == ACP_DS_BUSY && isSetMax && !setMaxBad) begin
				case (feat_q)
					8'h00: begin
						curMax_q <= lba_q;
						if (persist) begin
							nvMax_q <= lba_q;
							nvSetDone_q <= 1'b1;
						end
					end
					`ACP_FEAT_PASSWORD: pwSet_q <= 1'b1;
					`ACP_FEAT_LOCK: locked_q <= 1'b1;
					`ACP_FEAT_UNLOCK: locked_q <= 1'b0;
					`ACP_FEAT_FREEZE: frozen_q <= 1'b1;
					default: locked_q <= locked_q; // reserved already aborted
				endcase
			end
		end
	end

	// read-native chaining: only the very next command may be set-max
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nativeOk_q <= 1'b0;
		end else if (state_q == ACP_DS_BUSY) begin
			nativeOk_q <= isNative;
		end
	end

	// block mode; off from power-on
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			multEn_q <= 1'b0;
			multSet_q <= 1'b0;
		end else if (state_q == ACP_DS_BUSY && isSetMult) begin
			multSet_q <= 1'b1;
			multEn_q <= countOk;
		end
	end

	// completion pulse, error flag and monitoring request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			abort_q <= 1'b0;
			smartReq_q <= 1'b0;
			smartFeat_q <= 8'h00;
		end else begin
			done_q <= (state_q == ACP_DS_BUSY);
			smartReq_q <= (state_q == ACP_DS_BUSY) && isSmart;
			if (state_q == ACP_DS_BUSY) begin
				abort_q <= anyAbort;
				smartFeat_q <= feat_q;
			end
		end
	end

	assign link.busy = busy_q;
	assign link.ready = ready_q;
	assign link.cmdDone = done_q;
	assign link.cmdAbort = abort_q;
	assign link.maxLba = curMax_q;
	assign link.multEnable = multEn_q;
	assign link.pwrState = pwr_q;
	assign link.idWord82 = 16'h0001 << `ACP_ID82_SMART_BIT;
	assign nvMaxLba = nvMax_q;
	assign maxLocked = locked_q;
	assign maxFrozen = frozen_q;
	assign smartReq = smartReq_q;
	assign smartFeat = smartFeat_q;
endmodule : acp_drive

//--- src/acp_defs.svh
// constants for the capacity / power command handler
// assumes inclusion by both ends, the decoder and the testbench; definitions only
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH
`define ACP_OP_RDNATIVE 8'hf8
`define ACP_OP_SETMAX 8'hf9
`define ACP_OP_SETMULT 8'hc6
`define ACP_OP_SLEEP_A 8'h99
`define ACP_OP_SLEEP_B 8'he6
`define ACP_OP_STBY_A 8'h96
`define ACP_OP_STBY_B 8'he2
`define ACP_OP_STBYI_A 8'h94
`define ACP_OP_STBYI_B 8'he0
`define ACP_OP_SMART 8'hb0
`define ACP_OP_WRMULT 8'hc5
`define ACP_OP_RDMULT 8'hc4
`define ACP_SMART_HI 8'hc2
`define ACP_SMART_LO 8'h4f
`define ACP_FEAT_PASSWORD 8'h01
`define ACP_FEAT_LOCK 8'h02
`define ACP_FEAT_UNLOCK 8'h03
`define ACP_FEAT_FREEZE 8'h04
`define ACP_DH_LBA_BIT 6
`define ACP_DH_DEV_BIT 4
`define ACP_SC_PERSIST_BIT 0
`define ACP_BLOCK_SUPPORTED 8'h01
`define ACP_ID82_SMART_BIT 0
`define ACP_NATIVE_MAX_RST 28'hfffffff
// host-side register offsets (host command port)
`define ACP_HREG_CMD 4'h0
`define ACP_HREG_FEAT 4'h1
`define ACP_HREG_COUNT 4'h2
`define ACP_HREG_LBA 4'h3
`define ACP_HREG_DH 4'h4
`define ACP_HREG_STATUS 4'h8
`define ACP_HREG_MAXLBA 4'h9
`define ACP_HREG_MODE 4'ha
`endif

//--- src/acp_pkg.sv
// types shared by both ends of the command link
// assumes acp_defs.svh is reachable by include path
package acp_pkg;
	// power state of the drive
	typedef enum logic [1:0] {
		ACP_PWR_ACTIVE = 2'b00,
		ACP_PWR_STANDBY = 2'b01,
		ACP_PWR_SLEEP = 2'b11
	} acp_pwr_t;
	// device handler states, gray along issue/busy/done
	typedef enum logic [1:0] {
		ACP_DS_IDLE = 2'b00,
		ACP_DS_BUSY = 2'b01,
		ACP_DS_DONE = 2'b11
	} acp_dstate_t;
	// host issue states
	typedef enum logic [1:0] {
		ACP_HS_IDLE = 2'b00,
		ACP_HS_WAIT = 2'b01,
		ACP_HS_DONE = 2'b11
	} acp_hstate_t;
endpackage : acp_pkg

//--- src/acp_link_if.sv
// task-file link between host controller and drive command handler
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface acp_link_if;
	logic cmdValid; // one-cycle pulse: command register written
	logic [7:0] cmdOpcode;
	logic [7:0] featReg;
	logic [7:0] countReg;
	logic [7:0] sectNum;
	logic [7:0] cylLow;
	logic [7:0] cylHigh;
	logic [7:0] driveHead;
	logic busy; // drive busy level
	logic ready; // drive ready level
	logic cmdDone; // one-cycle completion interrupt
	logic cmdAbort; // aborted-command error, valid with cmdDone
	logic [27:0] maxLba; // current max address
	logic multEnable;
	logic [1:0] pwrState;
	logic [15:0] idWord82;
	modport drive (input cmdValid, cmdOpcode, featReg, countReg, sectNum, cylLow,
		cylHigh, driveHead, output busy, ready, cmdDone, cmdAbort, maxLba,
		multEnable, pwrState, idWord82);
	modport host (output cmdValid, cmdOpcode, featReg, countReg, sectNum, cylLow,
		cylHigh, driveHead, input busy, ready, cmdDone, cmdAbort, maxLba,
		multEnable, pwrState, idWord82);
endinterface : acp_link_if

//--- src/acp_opdec.sv
// opcode decoder: folds alias opcodes into one class each
// assumes a purely combinational use inside the drive end
`timescale 1ns/10ps
`include "acp_defs.svh"
module acp_opdec (
	input wire logic [7:0] opcode,
	input wire logic [7:0] cylLow,
	input wire logic [7:0] cylHigh,
	output logic isSleep,
	output logic isStandby,
	output logic isStandbyNow,
	output logic isSmart,
	output logic isSetMax,
	output logic isNative,
	output logic isSetMult,
	output logic isMulti
);
	// both legacy and current codes accepted
	assign isSleep = (opcode == `ACP_OP_SLEEP_A) || (opcode == `ACP_OP_SLEEP_B);
	assign isStandby = (opcode == `ACP_OP_STBY_A) || (opcode == `ACP_OP_STBY_B);
	assign isStandbyNow = (opcode == `ACP_OP_STBYI_A) || (opcode == `ACP_OP_STBYI_B);
	// monitoring needs its signature bytes too
	assign isSmart = (opcode == `ACP_OP_SMART) && (cylHigh == `ACP_SMART_HI)
		&& (cylLow == `ACP_SMART_LO);
	assign isSetMax = (opcode == `ACP_OP_SETMAX);
	assign isNative = (opcode == `ACP_OP_RDNATIVE);
	assign isSetMult = (opcode == `ACP_OP_SETMULT);
	assign isMulti = (opcode == `ACP_OP_WRMULT) || (opcode == `ACP_OP_RDMULT);
endmodule : acp_opdec

//--- src/acp_host.sv
// host end: software register port drives the task file link
// assumes software writes task registers, then command register to issue
`timescale 1ns/10ps
`include "acp_defs.svh"
module acp_host (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	acp_link_if.host link
);
	import acp_pkg::*;

	acp_hstate_t st_q; // issue state
	logic [7:0] op_q, feat_q, cnt_q, dh_q; // task registers
	logic [23:0] lba_q; // cyl high, cyl low, sector
	logic issue_q; // command pulse
	logic lastAbort_q; // sticky result of last command
	logic doneSeen_q; // a command has finished since issue
	logic [31:0] rdata_q;

	wire canIssue = (st_q == ACP_HS_IDLE) && link.ready && !link.busy;
	wire cmdWr = regWr && (regAddr == `ACP_HREG_CMD) && canIssue;

	// task register writes; drive/head forced to lba mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			feat_q <= 8'h00;
			cnt_q <= 8'h00;
			lba_q <= 24'h000000;
			dh_q <= 8'h40;
			op_q <= 8'h00;
		end else if (regWr) begin
			case (regAddr)
				`ACP_HREG_FEAT: feat_q <= regWdata[7:0];
				`ACP_HREG_COUNT: cnt_q <= regWdata[7:0];
				`ACP_HREG_LBA: lba_q <= regWdata[23:0];
				`ACP_HREG_DH: dh_q <= regWdata[7:0] | (8'h01 << `ACP_DH_LBA_BIT);
				`ACP_HREG_CMD: op_q <= canIssue ? regWdata[7:0] : op_q;
				default: op_q <= op_q;
			endcase
		end
	end

	// issue and wait for the completion pulse
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ACP_HS_IDLE;
			issue_q <= 1'b0;
			lastAbort_q <= 1'b0;
			doneSeen_q <= 1'b0;
		end else begin
			issue_q <= cmdWr;
			case (st_q)
				ACP_HS_IDLE: if (cmdWr) begin
					st_q <= ACP_HS_WAIT;
					doneSeen_q <= 1'b0;
				end
				ACP_HS_WAIT: if (link.cmdDone) begin
					st_q <= ACP_HS_DONE;
					lastAbort_q <= link.cmdAbort;
					doneSeen_q <= 1'b1;
				end
				ACP_HS_DONE: st_q <= ACP_HS_IDLE;
				default: st_q <= ACP_HS_IDLE;
			endcase
		end
	end

	// status words read back one cycle later
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				`ACP_HREG_STATUS: rdata_q <= {16'h0000, link.idWord82[7:0], link.pwrState,
					link.multEnable, lastAbort_q, doneSeen_q, link.ready, link.busy,
					st_q == ACP_HS_IDLE};
				`ACP_HREG_MAXLBA: rdata_q <= {4'h0, link.maxLba};
				`ACP_HREG_MODE: rdata_q <= {24'h000000, cnt_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	assign regRdata = rdata_q;
	assign link.cmdValid = issue_q;
	assign link.cmdOpcode = op_q;
	assign link.featReg = feat_q;
	assign link.countReg = cnt_q;
	assign link.sectNum = lba_q[7:0];
	assign link.cylLow = lba_q[15:8];
	assign link.cylHigh = lba_q[23:16];
	assign link.driveHead = dh_q;
endmodule : acp_host

//--- testbench/acp_link_assertions.sv
// checker for the task-file link between host and drive ends
// assumes the bench hands over the interface signals with the shared clock
`timescale 1ns/10ps
`include "acp_defs.svh"
module acp_link_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire logic [7:0] cmdOpcode,
	input wire logic [7:0] featReg,
	input wire logic [7:0] countReg,
	input wire logic [7:0] sectNum,
	input wire logic [7:0] cylLow,
	input wire logic [7:0] cylHigh,
	input wire logic [7:0] driveHead,
	input wire logic busy,
	input wire logic cmdDone,
	input wire logic cmdAbort,
	input wire logic [27:0] maxLba,
	input wire logic multEnable,
	input wire logic [1:0] pwrState
);
	import acp_pkg::*;
	wire isSleepOp; // either sleep alias
	wire isStbyOp; // standby or standby immediate aliases
	wire isSetMax; // capacity limit opcode
	wire isSetMult; // block count opcode
	assign isSleepOp = cmdValid && (cmdOpcode == 8'h99 || cmdOpcode == 8'he6);
	assign isStbyOp = cmdValid && (cmdOpcode == 8'h96 || cmdOpcode == 8'he2
		|| cmdOpcode == 8'h94 || cmdOpcode == 8'he0);
	assign isSetMax = cmdValid && cmdOpcode == `ACP_OP_SETMAX;
	assign isSetMult = cmdValid && cmdOpcode == `ACP_OP_SETMULT;
	// one clock domain, so one default for all
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	issue_busy_a: assert property (cmdValid |=> busy ##1 (!busy && cmdDone))
		else $error("busy then done missing after issue");
	lba_bit_a: assert property (cmdValid |-> driveHead[`ACP_DH_LBA_BIT])
		else $error("address-type bit low at issue");
	sleep_enter_a: assert property (isSleepOp |-> ##2 cmdDone && pwrState == ACP_PWR_SLEEP)
		else $error("sleep alias not decoded");
	stby_enter_a: assert property (isStbyOp |-> ##2 pwrState == ACP_PWR_STANDBY)
		else $error("standby alias not decoded");
	wake_up_a: assert property (cmdValid && !isSleepOp && !isStbyOp |->
		##[1:2] pwrState == ACP_PWR_ACTIVE) else $error("drive stayed in low power");
	mult_good_a: assert property (isSetMult && countReg == 8'h01 |->
		##2 multEnable && !cmdAbort) else $error("supported block count refused");
	mult_bad_a: assert property (isSetMult && countReg > 8'h01 |->
		##2 cmdAbort && !multEnable) else $error("unsupported block count accepted");
	mult_zero_a: assert property (isSetMult && countReg == 8'h00 |->
		##2 !multEnable && !cmdAbort) else $error("zero block count mishandled");
	// registers are held by the host until done, so they can be read at done
	limit_take_a: assert property (isSetMax && featReg == 8'h00 |-> ##2 cmdAbort ||
		maxLba == {driveHead[3:0], cylHigh, cylLow, sectNum}) else $error("limit not taken");
	feat_resv_a: assert property (isSetMax && featReg > 8'h04 |-> ##2 cmdAbort)
		else $error("reserved feature not aborted");
endmodule : acp_link_assertions

//--- testbench/ata_capacity_power_cmds_bench.sv
// bench driving the host register port; both ends joined by the link
// assumes host offsets and status layout as handed over by the designer
`timescale 1ns/10ps
`include "acp_defs.svh"
module ata_capacity_power_cmds_bench;
	import acp_pkg::*;
	logic sys_clk; // 20 MHz
	logic rst_n;
	logic [3:0] regAddr;
	logic [31:0] regWdata;
	logic regWr;
	logic regRd;
	logic [31:0] regRdata;
	logic [27:0] nvMaxLba;
	logic maxLocked;
	logic maxFrozen;
	logic smartReq;
	logic [7:0] smartFeat;
	logic [31:0] d; // read result
	logic gotAbort; // abort seen with done
	logic gotSmart; // monitoring request seen with done
	int mismatches = 0;
	int samplesChecked = 0;
	int cycles = 0;
	logic [7:0] lpOp [6] = '{8'h99, 8'he6, 8'h96, 8'he2, 8'h94, 8'he0};
	acp_pwr_t lpExp [6] = '{ACP_PWR_SLEEP, ACP_PWR_SLEEP, ACP_PWR_STANDBY,
		ACP_PWR_STANDBY, ACP_PWR_STANDBY, ACP_PWR_STANDBY};
	acp_link_if link ();
	acp_drive acp_drive_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.drive),
		.nvMaxLba(nvMaxLba), .maxLocked(maxLocked), .maxFrozen(maxFrozen),
		.smartReq(smartReq), .smartFeat(smartFeat));
	acp_host acp_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.link(link.host));
	acp_link_assertions acp_link_assertions_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.cmdValid(link.cmdValid), .cmdOpcode(link.cmdOpcode), .featReg(link.featReg),
		.countReg(link.countReg), .sectNum(link.sectNum), .cylLow(link.cylLow),
		.cylHigh(link.cylHigh), .driveHead(link.driveHead), .busy(link.busy),
		.cmdDone(link.cmdDone), .cmdAbort(link.cmdAbort), .maxLba(link.maxLba),
		.multEnable(link.multEnable), .pwrState(link.pwrState));
	// free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// hang guard, well above the ~750 cycles the run needs
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic conclude();
		$display("mismatches %0d samplesChecked %0d", mismatches, samplesChecked);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one-cycle strobe; the gap cycle keeps strobe edges apart
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1;
		v = regRdata;
	endtask : rd
	// task registers first, command last; abort checked unless exp is x
	task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] cnt,
		input logic [27:0] lba, input logic expAbort);
		int n;
		logic seen;
		wr(`ACP_HREG_FEAT, {24'h0, ft});
		wr(`ACP_HREG_COUNT, {24'h0, cnt});
		wr(`ACP_HREG_LBA, {8'h0, lba[23:0]});
		wr(`ACP_HREG_DH, {28'h0, lba[27:24]});
		wr(`ACP_HREG_CMD, {24'h0, op});
		seen = 1'b0;
		for (n = 0; n < 12 && !seen; n++) begin
			@(posedge sys_clk);
			#1;
			seen = link.cmdDone === 1'b1;
			gotAbort = link.cmdAbort;
			gotSmart = smartReq;
		end
		chk({31'h0, seen}, 32'h1);
		if (expAbort !== 1'bx) begin
			chk({31'h0, gotAbort}, {31'h0, expAbort});
		end
		repeat (4) @(posedge sys_clk);
	endtask : cmd
	// read-native first, so the chain is intact
	task automatic setMax(input logic [7:0] ft, input logic [7:0] cnt,
		input logic [27:0] lba, input logic expAbort);
		cmd(`ACP_OP_RDNATIVE, 8'h00, 8'h00, 28'h0, 1'b0);
		cmd(`ACP_OP_SETMAX, ft, cnt, lba, expAbort);
	endtask : setMax
	// main sequence
	initial begin
		regAddr = 4'h0;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		rst_n = 1'b0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`ACP_HREG_STATUS, d);
		chk(d & 32'h0000ffe4, 32'h00000104);
		cmd(`ACP_OP_SETMAX, 8'h00, 8'h00, 28'h0123456, 1'b1);
		chk({4'h0, link.maxLba}, {4'h0, `ACP_NATIVE_MAX_RST});
		rd(`ACP_HREG_STATUS, d);
		chk(d, 32'h0000011d);
		setMax(8'h00, 8'h00, 28'h7123456, 1'b0);
		rd(`ACP_HREG_MAXLBA, d);
		chk(d, 32'h07123456);
		chk({4'h0, nvMaxLba}, {4'h0, `ACP_NATIVE_MAX_RST});
		setMax(8'h00, 8'h01, 28'h0abcdef, 1'b0);
		chk({4'h0, nvMaxLba}, 32'h00abcdef);
		setMax(8'h00, 8'h01, 28'h0000100, 1'b1);
		chk({4'h0, link.maxLba}, 32'h00abcdef);
		setMax(8'h05, 8'h00, 28'h0000200, 1'b1);
		setMax(8'hff, 8'h00, 28'h0000200, 1'b1);
		setMax(`ACP_FEAT_PASSWORD, 8'h00, 28'h0, 1'b0);
		setMax(`ACP_FEAT_LOCK, 8'h00, 28'h0, 1'b0);
		chk({31'h0, maxLocked}, 32'h1);
		setMax(8'h00, 8'h00, 28'h0000300, 1'b1);
		setMax(`ACP_FEAT_UNLOCK, 8'h00, 28'h0, 1'b0);
		chk({31'h0, maxLocked}, 32'h0);
		setMax(`ACP_FEAT_FREEZE, 8'h00, 28'h0, 1'b0);
		chk({31'h0, maxFrozen}, 32'h1);
		setMax(`ACP_FEAT_LOCK, 8'h00, 28'h0, 1'b1);
		setMax(`ACP_FEAT_UNLOCK, 8'h00, 28'h0, 1'b1);
		chk({31'h0, maxLocked}, 32'h0);
		cmd(`ACP_OP_WRMULT, 8'h00, 8'h01, 28'h0, 1'b1);
		cmd(`ACP_OP_SETMULT, 8'h00, 8'h01, 28'h0, 1'b0);
		chk({31'h0, link.multEnable}, 32'h1);
		cmd(`ACP_OP_WRMULT, 8'h00, 8'h01, 28'h0, 1'b0);
		cmd(`ACP_OP_SETMULT, 8'h00, 8'h02, 28'h0, 1'b1);
		chk({31'h0, link.multEnable}, 32'h0);
		rd(`ACP_HREG_MODE, d);
		chk(d, 32'h00000002);
		cmd(`ACP_OP_RDMULT, 8'h00, 8'h01, 28'h0, 1'b1);
		cmd(`ACP_OP_SETMULT, 8'h00, 8'h01, 28'h0, 1'b0);
		cmd(`ACP_OP_SETMULT, 8'h00, 8'h00, 28'h0, 1'b0);
		chk({31'h0, link.multEnable}, 32'h0);
		// each alias, then wake with a harmless command
		for (int i = 0; i < 6; i++) begin
			cmd(lpOp[i], 8'h00, 8'h00, 28'h0, 1'b0);
			chk({30'h0, link.pwrState}, {30'h0, lpExp[i]});
			cmd(`ACP_OP_SETMULT, 8'h00, 8'h01, 28'h0, 1'b0);
			chk({30'h0, link.pwrState}, {30'h0, ACP_PWR_ACTIVE});
		end
		cmd(`ACP_OP_SMART, 8'hd0, 8'h00, 28'h0c24f00, 1'b0);
		chk({31'h0, gotSmart}, 32'h1);
		chk({24'h0, smartFeat}, 32'h000000d0);
		cmd(`ACP_OP_SMART, 8'hd0, 8'h00, 28'h0c24e00, 1'bx);
		chk({31'h0, gotSmart}, 32'h0);
		conclude();
	end
endmodule : ata_capacity_power_cmds_bench
